// File: src/ldrb_register_bank.sv
// Summary of operation
// R1: 8-bit sar converts all six channels automatically, storing results without host help.
// R2: string voltages sampled only while string active; else old result kept.
// R3: host reads never disturb conversions; reads see latest stored value.
// R4: boost sampled at least every 17 us, battery every 108 us.
// R5: strings sampled about every 52 us while active, temperatures every 4 ms.
// R6: 3-bit select points to result: boost,battery,str1,str2,temp1,temp2; 110/111 unused.
// R7: result register follows each newer result of the selected channel.
// R8: booster runs fixed frequency chosen by three-bit setting.
// R9: booster disable bit 7 of booster control stops switching.
// R10: booster control holds disable, 3-bit frequency, 4-bit range; resets zero.
// R11: offset 0x08 holds off-time range, derating disable, dimming frequency factor.
// R12: offsets 0x01/0x02 hold 8-bit dimming duty per string, reset zero.
// R13: 0x03/0x04 hold 7-bit current; bit 7 is read-only lock flag.
// R14: otp, otp data, converter control, test registers writable only in test mode.
// R15: 0x05/0x06 hold 8-bit short thresholds, cleared on reset.
// R16: status registers report parity, thermal, serial error and string flags.
// R17: 0x0f writes test command, reads revision; 0x00 is no-operation.
// R18: dimming measured and rebuilt at 10 us resolution, 50 to 8000 Hz; dim_out passes the synchronised input on at clock resolution.
// R19: each string has its own dimming input, constant frequency from the host.
// R20: otp command: point, read and refresh, load for emulation, program.
// R21: otp data read returns contents at selected otp address.
// R22: writes to read-only fields ignored; reads show live values.
module ldrb_register_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire ldrb_pkg::ldrb_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic test_mode_pin,
   input wire logic [1:0] string_dim_input,
   input wire logic [1:0] string_active,
   input wire logic [7:0] sar_sample,
   input wire logic sar_cmp,
   input wire logic factory_lock_flag,
   input wire logic user_lock_flag,
   input wire logic [6:0] string1_flags,
   input wire logic [5:0] string2_thermal_flags,
   input wire logic [7:0] otp_read_data,
   output logic [2:0] mux_select,
   output logic [7:0] sar_dac,
   output logic sar_sampling,
   output logic boost_run,
   output ldrb_pkg::ldrb_boost_t boost_cfg,
   output ldrb_pkg::ldrb_offdim_t offdim_cfg,
   output logic [7:0] dim_duty1,
   output logic [7:0] dim_duty2,
   output logic [6:0] current1,
   output logic [6:0] current2,
   output logic [7:0] short_limit1,
   output logic [7:0] short_limit2,
   output logic [3:0] toff2_range,
   output ldrb_pkg::ldrb_otp_req_t otp_req,
   output logic [7:0] test_cmd,
   output logic test_cmd_stb,
   output logic [1:0] dim_out,
   output logic [15:0] dim_period1,
   output logic [15:0] dim_period2
);

   localparam int NCH = ldrb_pkg::NUM_CH;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT,
      ST_STORE
   } ldrb_sar_st_t;

   typedef struct packed {
      logic [1:0] tst_s1;
      logic [1:0] tst_s2;
      logic [1:0] act_s1;
      logic [1:0] act_s2;
      logic [1:0] dim_s1;
      logic [1:0] dim_s2;
      logic [1:0] dim_prev;
      logic [7:0] dim1;
      logic [7:0] dim2;
      logic [6:0] cur1;
      logic [6:0] cur2;
      logic [7:0] sht1;
      logic [7:0] sht2;
      ldrb_pkg::ldrb_boost_t boost;
      ldrb_pkg::ldrb_offdim_t offdim;
      ldrb_pkg::ldrb_otpctl_t otpctl;
      logic [7:0] otpdat;
      ldrb_pkg::ldrb_convsel_t convsel;
      logic [7:0] tcmd;
      logic tcmd_stb;
      logic [7:0] rdata;
      logic rvalid;
      logic [NCH*8-1:0] results;
      logic [NCH-1:0] pending;
      logic [2:0] ch;
      ldrb_sar_st_t st;
      logic [2:0] bitn;
      logic [7:0] sar;
      logic [7:0] sample;
      logic [15:0] t_boost;
      logic [15:0] t_batt;
      logic [15:0] t_str;
      logic [17:0] t_temp;
      logic [15:0] t_dim;
      logic [31:0] dim_cnt;
      logic [31:0] dim_per;
   } ldrb_state_t;

   ldrb_state_t s_r;
   ldrb_state_t s_nxt;
   logic test_q;

   assign test_q = s_r.tst_s2[1];

   always_comb begin
      logic [7:0] rd;
      logic [2:0] pick;
      rd = 8'h00;
      pick = 3'h0;
      s_nxt = s_r;
      s_nxt.tst_s1 = {test_mode_pin, test_mode_pin};
      s_nxt.tst_s2 = s_r.tst_s1;
      s_nxt.act_s1 = string_active;
      s_nxt.act_s2 = s_r.act_s1;
      s_nxt.dim_s1 = string_dim_input;
      s_nxt.dim_s2 = s_r.dim_s1;
      s_nxt.tcmd_stb = 1'b0;
      s_nxt.rvalid = req.rd;

      // otp start is a one-shot request; a new write below wins over the clear
      if (s_r.otpctl.start) begin
         s_nxt.otpctl.start = 1'b0;
      end

      // host writes; unlisted and read-only offsets fall through
      if (req.wr) begin
         case (req.addr)
            ldrb_pkg::ADDR_DIM1: s_nxt.dim1 = req.wdata; // [R12]
            ldrb_pkg::ADDR_DIM2: s_nxt.dim2 = req.wdata; // [R12]
            ldrb_pkg::ADDR_CUR1: s_nxt.cur1 = req.wdata[6:0]; // [R13]
            ldrb_pkg::ADDR_CUR2: s_nxt.cur2 = req.wdata[6:0]; // [R13]
            ldrb_pkg::ADDR_SHT1: s_nxt.sht1 = req.wdata; // [R15]
            ldrb_pkg::ADDR_SHT2: s_nxt.sht2 = req.wdata; // [R15]
            ldrb_pkg::ADDR_BOOST: s_nxt.boost = req.wdata; // [R10]
            ldrb_pkg::ADDR_OFFDIM: s_nxt.offdim = req.wdata; // [R11]
            ldrb_pkg::ADDR_OTPCTL: begin
               if (test_q) begin
                  s_nxt.otpctl = req.wdata; // [R14] [R20]
                  s_nxt.otpctl.rsvd = 1'b0;
               end
            end
            ldrb_pkg::ADDR_OTPDAT: begin
               if (test_q) begin
                  s_nxt.otpdat = req.wdata; // [R14]
               end
            end
            ldrb_pkg::ADDR_CONVSEL: begin
               if (test_q) begin
                  s_nxt.convsel = req.wdata; // [R14] [R6]
               end
            end
            ldrb_pkg::ADDR_TESTREV: begin
               if (test_q) begin
                  s_nxt.tcmd = req.wdata; // [R14] [R17]
                  s_nxt.tcmd_stb = 1'b1;
               end
            end
            default: begin
            end // [R22]
         endcase
      end
      // stored channel leaves the queue; a fresh expiry below wins over this clear
      if (s_r.st == ST_STORE) begin
         s_nxt.pending[s_r.ch] = 1'b0;
      end

      // scheduler: each channel marks pending when its timer expires; strings only while active
      s_nxt.t_boost = s_r.t_boost + 16'h0001;
      s_nxt.t_batt = s_r.t_batt + 16'h0001;
      s_nxt.t_str = s_r.t_str + 16'h0001;
      s_nxt.t_temp = s_r.t_temp + 18'h00001;
      // boost deadline leaves room for a full conversion
      if (s_r.t_boost >= 16'(ldrb_pkg::BOOST_CYC - 2 * ldrb_pkg::SAR_BITS)) begin // [R4]
         s_nxt.t_boost = 16'h0000;
         s_nxt.pending[ldrb_pkg::CH_BOOST] = 1'b1;
      end
      if (s_r.t_batt >= 16'(ldrb_pkg::BATT_CYC - 1)) begin // [R4]
         s_nxt.t_batt = 16'h0000;
         s_nxt.pending[ldrb_pkg::CH_BATT] = 1'b1;
      end
      if (s_r.t_str >= 16'(ldrb_pkg::STRING_CYC - 1)) begin // [R5]
         s_nxt.t_str = 16'h0000;
         s_nxt.pending[ldrb_pkg::CH_STR1] = s_r.act_s2[0]; // [R2]
         s_nxt.pending[ldrb_pkg::CH_STR2] = s_r.act_s2[1]; // [R2]
      end
      if (s_r.t_temp >= 18'(ldrb_pkg::TEMP_CYC - 1)) begin // [R5]
         s_nxt.t_temp = 18'h00000;
         s_nxt.pending[ldrb_pkg::CH_TEMP1] = 1'b1;
         s_nxt.pending[ldrb_pkg::CH_TEMP2] = 1'b1;
      end

      // sar sequencer, independent of host access
      case (s_r.st) // [R1] [R3]
         ST_IDLE: begin
            for (int i = NCH - 1; i >= 0; i--) begin
               if (s_r.pending[i]) begin
                  pick = 3'(i);
               end
            end
            if (|s_r.pending) begin
               s_nxt.ch = pick;
               s_nxt.st = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            s_nxt.sar = 8'h80;
            s_nxt.sample = 8'h00;
            s_nxt.bitn = 3'h7;
            s_nxt.st = ST_CONVERT;
         end
         ST_CONVERT: begin
            // comparator high: keep trial bit
            s_nxt.sample = sar_cmp ? s_r.sar : s_r.sample;
            if (s_r.bitn == 3'h0) begin
               s_nxt.st = ST_STORE;
            end else begin
               s_nxt.bitn = s_r.bitn - 3'h1;
               s_nxt.sar = (sar_cmp ? s_r.sar : s_r.sample) | (8'h01 << (s_r.bitn - 3'h1));
            end
         end
         ST_STORE: begin
            // string lost its drive mid-conversion: keep old value
            if (!((s_r.ch == ldrb_pkg::CH_STR1 && !s_r.act_s2[0]) ||
                  (s_r.ch == ldrb_pkg::CH_STR2 && !s_r.act_s2[1]))) begin // [R2]
               s_nxt.results[s_r.ch*8 +: 8] = s_r.sample; // [R1]
            end
            s_nxt.st = ST_IDLE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase

      // dimming input period measurement at 10 us ticks
      s_nxt.t_dim = s_r.t_dim + 16'h0001;
      if (s_r.t_dim >= 16'(ldrb_pkg::DIM_RES_CYC - 1)) begin // [R18]
         s_nxt.t_dim = 16'h0000;
         // level kept per tick, so an edge between two ticks is still seen
         s_nxt.dim_prev = s_r.dim_s2;
         for (int k = 0; k < 2; k++) begin
            if (s_r.dim_s2[k] && !s_r.dim_prev[k]) begin // [R19]
               s_nxt.dim_per[k*16 +: 16] = s_r.dim_cnt[k*16 +: 16];
               s_nxt.dim_cnt[k*16 +: 16] = 16'h0001;
            end else if (s_r.dim_cnt[k*16 +: 16] < 16'(ldrb_pkg::DIM_MAX_TICKS)) begin
               s_nxt.dim_cnt[k*16 +: 16] = s_r.dim_cnt[k*16 +: 16] + 16'h0001;
            end
         end
      end

      // read mux: live values, sampled in one cycle
      case (req.addr)
         ldrb_pkg::ADDR_DIM1: rd = s_r.dim1;
         ldrb_pkg::ADDR_DIM2: rd = s_r.dim2;
         ldrb_pkg::ADDR_CUR1: rd = {factory_lock_flag, s_r.cur1}; // [R13]
         ldrb_pkg::ADDR_CUR2: rd = {user_lock_flag, s_r.cur2}; // [R13]
         ldrb_pkg::ADDR_SHT1: rd = s_r.sht1;
         ldrb_pkg::ADDR_SHT2: rd = s_r.sht2;
         ldrb_pkg::ADDR_BOOST: rd = s_r.boost;
         ldrb_pkg::ADDR_OFFDIM: rd = s_r.offdim;
         ldrb_pkg::ADDR_OTPCTL: rd = s_r.otpctl;
         ldrb_pkg::ADDR_OTPDAT: rd = otp_read_data; // [R21]
         ldrb_pkg::ADDR_CONVSEL: rd = s_r.convsel;
         ldrb_pkg::ADDR_STAT1: rd = {^string1_flags, string1_flags}; // [R16] [R22]
         ldrb_pkg::ADDR_STAT2: rd = {^string2_thermal_flags, string2_thermal_flags, 1'b0}; // [R16]
         ldrb_pkg::ADDR_RESULT: begin
            if (s_r.convsel.sel < 3'(NCH)) begin
               rd = s_r.results[s_r.convsel.sel*8 +: 8]; // [R6] [R7] [R3]
            end
         end
         ldrb_pkg::ADDR_TESTREV: rd = ldrb_pkg::SILICON_REVISION; // [R17]
         default: rd = 8'h00;
      endcase
      if (req.rd) begin
         s_nxt.rdata = rd;
      end

      if (!rst_n) begin
         s_nxt = '0;
         s_nxt.st = ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign rdata = s_r.rdata;
   assign rvalid = s_r.rvalid;
   assign mux_select = s_r.ch;
   assign sar_dac = s_r.sar;
   assign sar_sampling = (s_r.st == ST_SAMPLE);
   assign boost_run = ~s_r.boost.boost_off_bit; // [R9] [R8]
   assign boost_cfg = s_r.boost;
   assign offdim_cfg = s_r.offdim;
   assign dim_duty1 = s_r.dim1;
   assign dim_duty2 = s_r.dim2;
   assign current1 = s_r.cur1;
   assign current2 = s_r.cur2;
   assign short_limit1 = s_r.sht1;
   assign short_limit2 = s_r.sht2;
   assign toff2_range = s_r.convsel.toff2_range;
   assign otp_req = {s_r.otpctl.start, s_r.otpctl.cmd, s_r.otpctl.addr, s_r.otpdat}; // [R20]
   assign test_cmd = s_r.tcmd;
   assign test_cmd_stb = s_r.tcmd_stb;
   assign dim_out = s_r.dim_s2;
   assign dim_period1 = s_r.dim_per[15:0];
   assign dim_period2 = s_r.dim_per[31:16];

endmodule // ldrb_register_bank

// File: src/ldrb_pkg.sv
package ldrb_pkg;

   // register offsets
   localparam logic [3:0] ADDR_NOP = 4'h0;
   localparam logic [3:0] ADDR_DIM1 = 4'h1;
   localparam logic [3:0] ADDR_DIM2 = 4'h2;
   localparam logic [3:0] ADDR_CUR1 = 4'h3;
   localparam logic [3:0] ADDR_CUR2 = 4'h4;
   localparam logic [3:0] ADDR_SHT1 = 4'h5;
   localparam logic [3:0] ADDR_SHT2 = 4'h6;
   localparam logic [3:0] ADDR_BOOST = 4'h7;
   localparam logic [3:0] ADDR_OFFDIM = 4'h8;
   localparam logic [3:0] ADDR_OTPCTL = 4'h9;
   localparam logic [3:0] ADDR_OTPDAT = 4'ha;
   localparam logic [3:0] ADDR_CONVSEL = 4'hb;
   localparam logic [3:0] ADDR_STAT1 = 4'hc;
   localparam logic [3:0] ADDR_STAT2 = 4'hd;
   localparam logic [3:0] ADDR_RESULT = 4'he;
   localparam logic [3:0] ADDR_TESTREV = 4'hf;

   localparam logic [7:0] REG_RESET = 8'h00;
   // arbitrary neutral value
   localparam logic [7:0] SILICON_REVISION = 8'h5a;

   // field positions
   localparam int BOOST_OFF_POS = 7;
   localparam int LOCK_POS = 7;
   localparam int OTP_START_POS = 7;
   localparam int DERATE_OFF_POS = 3;

   // clock and sample timing
   localparam int CLK_MHZ = 40;
   localparam int BOOST_PERIOD_US = 17;
   localparam int BATT_PERIOD_US = 108;
   localparam int STRING_PERIOD_US = 52;
   localparam int TEMP_PERIOD_MS = 4;
   localparam int DIM_RES_US = 10;
   localparam int BOOST_CYC = BOOST_PERIOD_US * CLK_MHZ;
   localparam int BATT_CYC = BATT_PERIOD_US * CLK_MHZ;
   localparam int STRING_CYC = STRING_PERIOD_US * CLK_MHZ;
   localparam int TEMP_CYC = TEMP_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int DIM_RES_CYC = DIM_RES_US * CLK_MHZ;
   localparam int DIM_MIN_HZ = 50;
   localparam int DIM_MAX_HZ = 8000;
   // dimming period ticks at the lowest input frequency
   localparam int DIM_MAX_TICKS = 1000000 / (DIM_MIN_HZ * DIM_RES_US);
   // sar conversion: one cycle per bit
   localparam int SAR_BITS = 8;
   localparam int NUM_CH = 6;

   typedef enum logic [2:0] {
      CH_BOOST = 3'h0,
      CH_BATT = 3'h1,
      CH_STR1 = 3'h2,
      CH_STR2 = 3'h3,
      CH_TEMP1 = 3'h4,
      CH_TEMP2 = 3'h5
   } ldrb_ch_t;

   typedef enum logic [1:0] {
      OTP_POINT = 2'h0,
      OTP_READ = 2'h1,
      OTP_LOAD = 2'h2,
      OTP_PROG = 2'h3
   } ldrb_otp_cmd_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } ldrb_req_t;

   typedef struct packed {
      logic boost_off_bit;
      logic [2:0] boost_freq;
      logic [3:0] boost_range;
   } ldrb_boost_t;

   typedef struct packed {
      logic [3:0] toff1_range;
      logic derating_off_bit;
      logic [2:0] dim_freq_multiplier;
   } ldrb_offdim_t;

   typedef struct packed {
      logic start;
      logic [1:0] cmd;
      logic rsvd;
      logic [3:0] addr;
   } ldrb_otpctl_t;

   typedef struct packed {
      logic tst_en;
      logic [3:0] toff2_range;
      logic [2:0] sel;
   } ldrb_convsel_t;

   typedef struct packed {
      logic otp_start;
      logic [1:0] otp_cmd;
      logic [3:0] otp_addr;
      logic [7:0] otp_data;
   } ldrb_otp_req_t;

endpackage

// File: tb/ldrb_analog_model.sv
module ldrb_analog_model (
   input wire logic [2:0] mux_select,
   input wire logic [7:0] sar_dac,
   input wire logic [5:0][7:0] level,
   output logic sar_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   // comparator of the front end; unused pointer codes never trip it
   always_comb sar_cmp = (mux_select < 3'h6) && (level[mux_select] >= sar_dac);
endmodule // ldrb_analog_model

// File: tb/ldrb_register_bank_asserts.sv
module ldrb_register_bank_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire ldrb_pkg::ldrb_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic test_mode_pin,
   input wire logic factory_lock_flag,
   input wire logic [6:0] string1_flags,
   input wire logic [2:0] mux_select,
   input wire logic sar_sampling,
   input wire logic boost_run,
   input wire ldrb_pkg::ldrb_boost_t boost_cfg,
   input wire logic [7:0] dim_duty1,
   input wire logic [6:0] current1,
   input wire ldrb_pkg::ldrb_otp_req_t otp_req,
   input wire logic test_cmd_stb
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [11:0] gap_r;
   logic [11:0] gap_nxt;
   // cycles since the last boost sample
   always_comb gap_nxt = (sar_sampling && mux_select == 3'h0) ? 12'h000 : gap_r + 12'h001;
   always_ff @(posedge clk) gap_r <= rst_n ? gap_nxt : 12'h000;
   read_answer_a: assert property (
      req.rd |=> rvalid) else $error("read not answered");
   duty_write_a: assert property (
      req.wr && req.addr == ldrb_pkg::ADDR_DIM1 |=> dim_duty1 == $past(req.wdata)) else $error("duty not stored");
   current_write_a: assert property (
      req.wr && req.addr == ldrb_pkg::ADDR_CUR1 |=> {1'b0, current1} == ($past(req.wdata) & 8'h7f))
      else $error("current not stored");
   lock_read_a: assert property (
      req.rd && req.addr == ldrb_pkg::ADDR_CUR1 |=> rdata[7] == $past(factory_lock_flag))
      else $error("lock bit wrong");
   revision_read_a: assert property (
      req.rd && req.addr == ldrb_pkg::ADDR_TESTREV |=> rdata == ldrb_pkg::SILICON_REVISION)
      else $error("revision wrong");
   status_read_a: assert property (
      req.rd && req.addr == ldrb_pkg::ADDR_STAT1 |=> rdata == {^$past(string1_flags), $past(string1_flags)})
      else $error("status wrong");
   boost_stop_a: assert property (
      req.wr && req.addr == ldrb_pkg::ADDR_BOOST
      |=> boost_run == !$past(req.wdata[7]) && boost_cfg == $past(req.wdata))
      else $error("boost run mismatch");
   otp_guard_a: assert property (
      (!test_mode_pin [*3] ##0 (req.wr && req.addr == ldrb_pkg::ADDR_OTPDAT)) |=> $stable(otp_req.otp_data))
      else $error("otp data written outside test");
   test_strobe_a: assert property (
      test_cmd_stb |-> $past(req.wr) && $past(req.addr) == ldrb_pkg::ADDR_TESTREV)
      else $error("stray test strobe");
   channel_range_a: assert property (
      mux_select < 3'h6) else $error("bad channel");
   boost_rate_a: assert property (
      gap_r < 12'h2a8) else $error("boost sample late");
   cover property (req.rd && req.addr == ldrb_pkg::ADDR_RESULT);
   cover property (test_cmd_stb);
   cover property (sar_sampling && mux_select == 3'h2);
endmodule // ldrb_register_bank_asserts
bind ldrb_register_bank ldrb_register_bank_asserts u_chk (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
   .rvalid(rvalid), .test_mode_pin(test_mode_pin), .factory_lock_flag(factory_lock_flag),
   .string1_flags(string1_flags), .mux_select(mux_select), .sar_sampling(sar_sampling), .boost_run(boost_run),
   .boost_cfg(boost_cfg), .dim_duty1(dim_duty1), .current1(current1), .otp_req(otp_req),
   .test_cmd_stb(test_cmd_stb));

// File: tb/ldrb_register_bank_tb.sv
module ldrb_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ldrb_pkg::ldrb_req_t req = '0;
   logic test_mode_pin = 1'b0;
   logic [1:0] dim_in = 2'h0;
   logic [1:0] str_act = 2'h3;
   logic lock_f = 1'b0;
   logic lock_u = 1'b1;
   logic [6:0] s1_flags = 7'h15;
   logic [5:0] s2_flags = 6'h0b;
   logic [7:0] otp_rd = 8'h3c;
   logic [5:0][7:0] level = 48'h10_20_30_40_50_60;
   logic [7:0] rdata, sar_dac, dim_duty1, short_limit2, test_cmd;
   logic [2:0] mux_select;
   logic [15:0] dim_period1, dim_period2;
   logic [7:0] dim_duty2, short_limit1;
   logic [6:0] current1, current2;
   logic [3:0] toff2_range;
   logic [1:0] dim_out;
   ldrb_pkg::ldrb_boost_t boost_cfg;
   ldrb_pkg::ldrb_offdim_t offdim_cfg;
   logic rvalid, sar_cmp, boost_run;
   ldrb_pkg::ldrb_otp_req_t otp_req;
   int fails = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   always begin
      repeat (4000) @(negedge clk);
      dim_in[0] = ~dim_in[0];
   end
   always begin
      repeat (5000) @(negedge clk);
      dim_in[1] = ~dim_in[1];
   end
   ldrb_register_bank u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
      .test_mode_pin(test_mode_pin), .string_dim_input(dim_in), .string_active(str_act), .sar_sample(8'h00),
      .sar_cmp(sar_cmp), .factory_lock_flag(lock_f), .user_lock_flag(lock_u), .string1_flags(s1_flags),
      .string2_thermal_flags(s2_flags), .otp_read_data(otp_rd), .mux_select(mux_select), .sar_dac(sar_dac),
      .sar_sampling(), .boost_run(boost_run), .boost_cfg(boost_cfg), .offdim_cfg(offdim_cfg),
      .dim_duty1(dim_duty1), .dim_duty2(dim_duty2), .current1(current1), .current2(current2),
      .short_limit1(short_limit1), .short_limit2(short_limit2), .toff2_range(toff2_range),
      .otp_req(otp_req), .test_cmd(test_cmd), .test_cmd_stb(), .dim_out(dim_out), .dim_period1(dim_period1),
      .dim_period2(dim_period2));
   ldrb_analog_model u_afe (.mux_select(mux_select), .sar_dac(sar_dac), .level(level), .sar_cmp(sar_cmp));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      chk("rvalid", 16'h0001, {15'h0, rvalid});
      chk(nm, {8'h00, e}, {8'h00, rdata});
   endtask
   task automatic t_reset;
      for (int a = 1; a < 12; a++)
         if (a != 10) rdchk("reset value", 4'(a), ldrb_pkg::REG_RESET | {a == 4 && lock_u, 7'h00});
      rdchk("otp data read", ldrb_pkg::ADDR_OTPDAT, 8'h3c);
      chk("boost run", 16'h0001, {15'h0, boost_run});
      $display("t_reset done");
   endtask
   task automatic t_rw;
      logic [7:0] d;
      for (int a = 1; a < 9; a++) begin
         d = {~4'(a), 4'(a)};
         wr(4'(a), d);
         if (a == 3) d[7] = 1'b0;
         rdchk("rw readback", 4'(a), d);
      end
      chk("boost run", 16'h0000, {15'h0, boost_run});
      chk("duty1", 16'h00e1, {8'h00, dim_duty1});
      chk("short2", 16'h0096, {8'h00, short_limit2});
      chk("duty2", 16'h00d2, {8'h00, dim_duty2});
      chk("current1", 16'h0043, {9'h000, current1});
      chk("current2", 16'h0034, {9'h000, current2});
      chk("short1", 16'h00a5, {8'h00, short_limit1});
      chk("offdim", 16'h0078, {8'h00, offdim_cfg});
      chk("boost cfg", 16'h0087, {8'h00, boost_cfg});
      wr(ldrb_pkg::ADDR_BOOST, 8'h07);
      chk("boost run", 16'h0001, {15'h0, boost_run});
      chk("boost cfg", 16'h0007, {8'h00, boost_cfg});
      lock_u = 1'b0;
      rdchk("live lock", ldrb_pkg::ADDR_CUR2, 8'h34);
      $display("t_rw done");
   endtask
   task automatic t_ro;
      wr(ldrb_pkg::ADDR_STAT1, 8'hff);
      wr(ldrb_pkg::ADDR_STAT2, 8'hff);
      wr(ldrb_pkg::ADDR_NOP, 8'hff);
      wr(ldrb_pkg::ADDR_TESTREV, 8'h11);
      rdchk("status1", ldrb_pkg::ADDR_STAT1, 8'h95);
      rdchk("status2", ldrb_pkg::ADDR_STAT2, 8'h96);
      s1_flags = 7'h03;
      rdchk("status1", ldrb_pkg::ADDR_STAT1, 8'h03);
      rdchk("revision", ldrb_pkg::ADDR_TESTREV, ldrb_pkg::SILICON_REVISION);
      rdchk("nop", ldrb_pkg::ADDR_NOP, 8'h00);
      rdchk("duty1", ldrb_pkg::ADDR_DIM1, 8'he1);
      chk("test cmd", 16'h0000, {8'h00, test_cmd});
      $display("t_ro done");
   endtask
   task automatic t_otp;
      wr(ldrb_pkg::ADDR_OTPDAT, 8'h5c);
      chk("otp data", 16'h0000, {8'h00, otp_req.otp_data});
      test_mode_pin = 1'b1;
      repeat (3) @(negedge clk);
      wr(ldrb_pkg::ADDR_OTPDAT, 8'ha7);
      chk("otp data", 16'h00a7, {8'h00, otp_req.otp_data});
      rdchk("otp data read", ldrb_pkg::ADDR_OTPDAT, 8'h3c);
      for (int c = 0; c < 4; c++) begin
         wr(ldrb_pkg::ADDR_OTPCTL, {1'b1, 2'(c), 1'b0, 4'(c + 9)});
         chk("otp cmd", {10'h0, 2'(c), 4'(c + 9)}, {10'h0, otp_req.otp_cmd, otp_req.otp_addr});
      end
      wr(ldrb_pkg::ADDR_TESTREV, 8'h3e);
      chk("test cmd", 16'h003e, {8'h00, test_cmd});
      $display("t_otp done");
   endtask
   task automatic t_adc;
      repeat (5000) @(negedge clk);
      for (int c = 0; c < 4; c++) begin
         wr(ldrb_pkg::ADDR_CONVSEL, {1'b0, 4'(c + 3), 3'(c)});
         chk("toff2", 16'(c + 3), {12'h000, toff2_range});
         rdchk("result", ldrb_pkg::ADDR_RESULT, level[c]);
      end
      wr(ldrb_pkg::ADDR_CONVSEL, 8'h02);
      str_act = 2'h2;
      level[2] = 8'h77;
      repeat (5000) @(negedge clk);
      rdchk("held string", ldrb_pkg::ADDR_RESULT, 8'h40);
      str_act = 2'h3;
      repeat (3000) @(negedge clk);
      rdchk("polled string", ldrb_pkg::ADDR_RESULT, 8'h77);
      test_mode_pin = 1'b0;
      repeat (3) @(negedge clk);
      wr(ldrb_pkg::ADDR_CONVSEL, 8'h7b);
      chk("toff2 locked", 16'h0000, {12'h000, toff2_range});
      $display("t_adc done");
   endtask
   task automatic t_dim;
      logic [1:0] d;
      repeat (10000) @(negedge clk);
      chk("period1", 16'h0001, {15'h0, dim_period1 >= 16'd19 && dim_period1 <= 16'd21});
      chk("period2", 16'h0001, {15'h0, dim_period2 >= 16'd24 && dim_period2 <= 16'd26});
      d = dim_in;
      repeat (3) @(negedge clk);
      if (dim_in == d) chk("dim out", {14'h0000, d}, {14'h0000, dim_out});
      $display("t_dim done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_reset;
      t_rw;
      t_ro;
      t_otp;
      t_adc;
      t_dim;
      finish_test;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      finish_test;
   end
endmodule // ldrb_register_bank_tb
